// >>> core/gpie_top.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
// What this block does
// - data write drives pins; data read returns live pin levels.
// - narrow port data read: upper nibble is the last bus value.
// - each enable bit gates its pin interrupt; zero blocks, one permits.
// - narrow port enable keeps four bits; upper nibble reads last bus.
// - one global mode bit in io_config_one selects the interrupt mode.
module gpie_top import gpie_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [NPIN-1:0] pin_in, // live pin levels
  output logic [NPIN-1:0] pin_out, // driven pin values
  output logic irq // level interrupt
);

  // register state
  logic [7:0] data_r [NPORT];
  logic [7:0] ie_r [NPORT];
  logic [7:0] mask_r [NPORT];
  logic [7:0] stat [NPORT];
  logic [7:0] pin_vec [NPORT];
  logic [7:0] clr_vec [NPORT];
  logic [7:0] evt_vec [NPORT];
  logic mode_r;
  logic [7:0] last_bus_r;

  // write channel state
  logic aw_held_r;
  logic w_held_r;
  logic [5:0] wr_idx_r;
  logic wr_align_r;
  logic [7:0] wr_byte_r;
  logic wr_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // read channel state
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // handshakes
  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic ar_fire;
  logic wr_ok;
  logic wr_store;
  logic rd_ok;
  gpie_dec_t wr_dec;
  gpie_dec_t rd_dec;

  // read selection wires
  logic [2:0] rp;
  logic [7:0] data_rd;
  logic [7:0] ie_rd;
  logic [7:0] rd_byte;
  logic [7:0] wr_masked;
  logic [NPORT-1:0] irq_port;

  // channel ready terms: one write and one read in flight at most
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;

  // write decode from the held address
  assign wr_dec = gpie_decode(wr_idx_r);
  assign wr_ok = (wr_dec.kind != KIND_NONE) && wr_align_r;
  assign wr_store = wr_go && wr_ok && wr_lane_r;
  // unimplemented pins of the narrow port never hold a one
  assign wr_masked = wr_byte_r & gpie_port_mask(wr_dec.port);

  // read decode straight from the address channel
  assign rd_dec = gpie_decode(s_axi_araddr[7:2]);
  assign rd_ok = (rd_dec.kind != KIND_NONE) && (s_axi_araddr[1:0] == 2'b00);
  assign rp = rd_dec.port;

  // data reads: live pins, enable reads: ie_r; narrow port upper nibble of both is the last bus value
  assign data_rd = (rp == 3'(NARROW_PORT)) ?
                   {last_bus_r[7:4], pin_vec[rp][3:0]} :
                   pin_vec[rp];
  assign ie_rd = (rp == 3'(NARROW_PORT)) ?
                 {last_bus_r[7:4], ie_r[rp][3:0]} :
                 ie_r[rp];

  // read data selection by register kind
  assign rd_byte = !rd_ok ? 8'h00 :
                   (rd_dec.kind == KIND_DATA) ? data_rd :
                   (rd_dec.kind == KIND_IE) ? ie_rd :
                   (rd_dec.kind == KIND_CFG) ? {7'h00, mode_r} :
                   (rd_dec.kind == KIND_STAT) ? stat[rp] :
                   (rd_dec.kind == KIND_MASK) ? mask_r[rp] :
                   8'h00;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      wr_idx_r <= 6'h00;
      wr_align_r <= 1'b0;
    end else if (aw_fire) begin
      aw_held_r <= 1'b1;
      wr_idx_r <= s_axi_awaddr[7:2];
      wr_align_r <= (s_axi_awaddr[1:0] == 2'b00);
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wr_byte_r <= 8'h00;
      wr_lane_r <= 1'b0;
    end else if (w_fire) begin
      w_held_r <= 1'b1;
      wr_byte_r <= s_axi_wdata[7:0];
      wr_lane_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // write response follows both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // internal data bus history: last byte written or read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_bus_r <= LAST_BUS_RST;
    end else if (wr_store) begin
      last_bus_r <= wr_byte_r;
    end else if (ar_fire && rd_ok) begin
      last_bus_r <= rd_byte;
    end
  end

  // global interrupt mode bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= IRQ_MODE_RST;
    end else if (wr_store && wr_dec.kind == KIND_CFG) begin
      mode_r <= wr_byte_r[IRQ_MODE_BIT];
    end
  end

  // per-port registers, pins and interrupt logic
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      localparam int W = (p == NARROW_PORT) ? NARROW_W : PORT_W;
      logic hit;
      logic [W-1:0] evt;

      assign hit = wr_store && (wr_dec.port == 3'(p));

      // data, enable and mask registers
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          data_r[p] <= PIN_DATA_RST;
          ie_r[p] <= IRQ_ENABLE_RST;
          mask_r[p] <= IRQ_MASK_RST;
        end else if (hit) begin
          if (wr_dec.kind == KIND_DATA) begin
            data_r[p] <= wr_masked;
          end
          if (wr_dec.kind == KIND_IE) begin
            ie_r[p] <= wr_masked;
          end
          if (wr_dec.kind == KIND_MASK) begin
            mask_r[p] <= wr_masked;
          end
        end
      end

      // pins driven from the data register, sampled back for reads
      assign pin_out[p*PORT_W +: W] = data_r[p][W-1:0];
      if (W < PORT_W) begin : g_narrow
        assign pin_vec[p] = {{(PORT_W-W){1'b0}}, pin_in[p*PORT_W +: W]};
        assign evt_vec[p] = {{(PORT_W-W){1'b0}}, evt};
      end else begin : g_full
        assign pin_vec[p] = pin_in[p*PORT_W +: W];
        assign evt_vec[p] = evt;
      end

      // write one to a status bit clears it
      assign clr_vec[p] = (hit && wr_dec.kind == KIND_STAT) ?
                          wr_masked : 8'h00;

      gpie_port #(
        .W(W)
      ) u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pin_in[p*PORT_W +: W]),
        .pin_data(data_r[p][W-1:0]),
        .irq_enable(ie_r[p][W-1:0]),
        .irq_mode(mode_r),
        .pin_event(evt)
      );

      gpie_sticky #(
        .W(PORT_W)
      ) u_stat (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(evt_vec[p]),
        .clr_in(clr_vec[p]),
        .status_r(stat[p])
      );

      assign irq_port[p] = |(stat[p] & mask_r[p]);
    end
  endgenerate

  // outputs
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign irq = |irq_port;

endmodule

// >>> core/gpie_pkg.sv
package gpie_pkg;

  // port geometry: four full ports and one narrow port
  localparam int NPORT = 5;
  localparam int PORT_W = 8;
  localparam int NARROW_PORT = 4;
  localparam int NARROW_W = 4;
  localparam int NPIN = 36;

  // register indexes; byte address is four times the index
  localparam logic [5:0] PORT0_PIN_DATA_IDX = 6'h00;
  localparam logic [5:0] PORT0_IRQ_ENABLE_IDX = 6'h01;
  localparam logic [5:0] PORT1_PIN_DATA_IDX = 6'h04;
  localparam logic [5:0] PORT1_IRQ_ENABLE_IDX = 6'h05;
  localparam logic [5:0] PORT2_PIN_DATA_IDX = 6'h08;
  localparam logic [5:0] PORT2_IRQ_ENABLE_IDX = 6'h09;
  localparam logic [5:0] PORT3_PIN_DATA_IDX = 6'h0c;
  localparam logic [5:0] PORT3_IRQ_ENABLE_IDX = 6'h0d;
  localparam logic [5:0] PORT4_PIN_DATA_IDX = 6'h10;
  localparam logic [5:0] PORT4_IRQ_ENABLE_IDX = 6'h11;
  localparam logic [5:0] IO_CONFIG_ONE_IDX = 6'h14;
  localparam logic [5:0] IRQ_STATUS_BASE_IDX = 6'h18;
  localparam logic [5:0] IRQ_MASK_BASE_IDX = 6'h20;

  // layout of the port block: stride of four, enable one above data
  localparam logic [1:0] PIN_DATA_SUB = 2'h0;
  localparam logic [1:0] IRQ_ENABLE_SUB = 2'h1;
  localparam logic [5:0] PORT_AREA_END_IDX = 6'h14;

  // field positions
  localparam int IRQ_MODE_BIT = 0;
  localparam logic [7:0] NARROW_MASK = 8'h0f;
  localparam logic [7:0] FULL_MASK = 8'hff;

  // reset values
  localparam logic [7:0] PIN_DATA_RST = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] LAST_BUS_RST = 8'h00;
  localparam logic IRQ_MODE_RST = 1'b0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // register kinds, one-hot
  typedef enum logic [5:0] {
    KIND_NONE = 6'b000001,
    KIND_DATA = 6'b000010,
    KIND_IE   = 6'b000100,
    KIND_CFG  = 6'b001000,
    KIND_STAT = 6'b010000,
    KIND_MASK = 6'b100000
  } gpie_kind_t;

  typedef struct packed {
    gpie_kind_t kind;
    logic [2:0] port;
  } gpie_dec_t;

  // map a word index onto a register kind and its port
  function automatic gpie_dec_t gpie_decode(input logic [5:0] idx);
    gpie_dec_t d;
    d.kind = KIND_NONE;
    d.port = 3'h0;
    if (idx < PORT_AREA_END_IDX) begin
      d.port = idx[4:2];
      if (idx[1:0] == PIN_DATA_SUB) begin
        d.kind = KIND_DATA;
      end else if (idx[1:0] == IRQ_ENABLE_SUB) begin
        d.kind = KIND_IE;
      end
    end else if (idx == IO_CONFIG_ONE_IDX) begin
      d.kind = KIND_CFG;
    end else if (idx >= IRQ_STATUS_BASE_IDX &&
                 idx < IRQ_STATUS_BASE_IDX + 6'(NPORT)) begin
      d.kind = KIND_STAT;
      d.port = 3'(idx - IRQ_STATUS_BASE_IDX);
    end else if (idx >= IRQ_MASK_BASE_IDX &&
                 idx < IRQ_MASK_BASE_IDX + 6'(NPORT)) begin
      d.kind = KIND_MASK;
      d.port = 3'(idx - IRQ_MASK_BASE_IDX);
    end
    return d;
  endfunction

  // bits that exist on a given port
  function automatic logic [7:0] gpie_port_mask(input logic [2:0] port);
    return (port == 3'(NARROW_PORT)) ? NARROW_MASK : FULL_MASK;
  endfunction

endpackage

// >>> core/gpie_port.sv
`timescale 1ns/10ps
// per-port pin event detector
module gpie_port import gpie_pkg::*; #(
  parameter int W = PORT_W
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [W-1:0] pin_in, // live pin levels
  input wire logic [W-1:0] pin_data, // value written to the port
  input wire logic [W-1:0] irq_enable, // per-pin enables
  input wire logic irq_mode, // global mode select
  output logic [W-1:0] pin_event // gated event per pin
);

  logic [W-1:0] prev_r;
  logic [W-1:0] change;
  logic [W-1:0] mismatch;

  // previous pin sample for change detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= pin_in;
    end
  end

  // mode 0: any change; mode 1: pin differs from its data value
  assign change = pin_in ^ prev_r;
  assign mismatch = pin_in ^ pin_data;
  assign pin_event = irq_enable & (irq_mode ? mismatch : change);

endmodule

// >>> core/gpie_sticky.sv
`timescale 1ns/10ps
// sticky status bits, write one to clear, set beats clear
module gpie_sticky #(
  parameter int W = 8
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [W-1:0] set_in, // events
  input wire logic [W-1:0] clr_in, // clear strobes
  output logic [W-1:0] status_r // sticky status
);

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~clr_in) | set_in;
    end
  end

endmodule

// >>> core/gpie_dummy_unused.sv
`timescale 1ns/10ps

// >>> test/gpie_pins_model.sv
`timescale 1ns/10ps
// pins: driven values loop back, bench may override single bits
module gpie_pins_model import gpie_pkg::*; (
  input wire logic [NPIN-1:0] pin_out, // driven pin values
  input wire logic [NPIN-1:0] ovr_en, // override select
  input wire logic [NPIN-1:0] ovr_val, // override level
  output logic [NPIN-1:0] pin_in // observed pin levels
);
  // a pin not overridden reads back what the block drives
  assign pin_in = (pin_out & ~ovr_en) | (ovr_val & ovr_en);
endmodule

// >>> test/gpie_top_sva.sv
`timescale 1ns/10ps
// port-level bus, pin and reset checks
module gpie_top_sva import gpie_pkg::*; (
  input wire logic aclk, // system clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [NPIN-1:0] pin_out, // driven pins
  input wire logic irq // interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // handshake steps
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // answer timing, holding and refusal
  a_write_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1
    s_axi_bvalid) else $error("write answer not in two cycles");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer not in one cycle");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("rdata upper bits set");
  a_pins_on_write: assert property ($changed(pin_out) |->
    $rose(s_axi_bvalid)) else $error("pins moved without a write");
  a_reset_clears: assert property (disable iff (1'b0)
    !aresetn |=> pin_out == '0 && !irq) else $error("reset left state");
endmodule

bind gpie_top gpie_top_sva chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_out, .irq);

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench import gpie_pkg::*;;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NPIN-1:0] pin_in, pin_out, ovr_en, ovr_val;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  gpie_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .irq);
  gpie_pins_model pins_u (.pin_out, .ovr_en, .ovr_val, .pin_in);
  // clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'b00};
  endfunction
  // one write: address and data together, then the response
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit aw_p;
    bit w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // each channel is released at the edge that takes it
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // one read, compared against the expected byte and response
  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, d});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // main sequence
  initial begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready} <= 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    s_axi_wstrb <= 4'h1;
    ovr_en <= '0;
    ovr_val <= '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int p = 0; p < 5; p++) begin
      rd(ba(6'(4 * p)), 8'h00, RESP_OKAY);
      rd(ba(6'(4 * p + 1)), 8'h00, RESP_OKAY);
    end
    chk(pin_out[31:0], 32'h0);
    chk({28'h0, pin_out[35:32]}, 32'h0);
    // written value drives pins, read returns pin levels
    wr(ba(PORT1_PIN_DATA_IDX), 8'ha5, RESP_OKAY);
    chk({24'h0, pin_out[15:8]}, 32'ha5);
    // a write with no byte strobe is answered but stores nothing
    s_axi_wstrb <= 4'h0;
    wr(ba(PORT1_PIN_DATA_IDX), 8'h11, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    chk({24'h0, pin_out[15:8]}, 32'ha5);
    ovr_en[15:8] <= 8'hff;
    ovr_val[15:8] <= 8'h3c;
    rd(ba(PORT1_PIN_DATA_IDX), 8'h3c, RESP_OKAY);
    // narrow port: upper nibble shows the last bus value
    wr(ba(PORT4_IRQ_ENABLE_IDX), 8'h0f, RESP_OKAY);
    wr(ba(PORT0_IRQ_ENABLE_IDX), 8'hc0, RESP_OKAY);
    rd(ba(PORT4_IRQ_ENABLE_IDX), 8'hcf, RESP_OKAY);
    ovr_en[35:32] <= 4'hf;
    ovr_val[35:32] <= 4'h5;
    rd(ba(PORT4_PIN_DATA_IDX), 8'hc5, RESP_OKAY);
    // narrow port drives only its four pins
    wr(ba(PORT4_PIN_DATA_IDX), 8'hfa, RESP_OKAY);
    chk({28'h0, pin_out[35:32]}, 32'ha);
    rd(8'h94, 8'h00, RESP_SLVERR);
    rd(8'h06, 8'h00, RESP_SLVERR);
    wr(8'h94, 8'h00, RESP_SLVERR);
    // enable gating in change mode
    wr(ba(PORT2_IRQ_ENABLE_IDX), 8'h08, RESP_OKAY);
    wr(ba(IRQ_MASK_BASE_IDX + 6'h2), 8'hff, RESP_OKAY);
    ovr_en[23:16] <= 8'hff;
    ovr_val[23:16] <= 8'h10;
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    ovr_val[23:16] <= 8'h18;
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(ba(IRQ_STATUS_BASE_IDX + 6'h2), 8'h08, RESP_OKAY);
    wr(ba(IRQ_STATUS_BASE_IDX + 6'h2), 8'h08, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    // level mode keeps setting while pin differs from data
    wr(ba(IO_CONFIG_ONE_IDX), 8'h01, RESP_OKAY);
    rd(ba(IO_CONFIG_ONE_IDX), 8'h01, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(ba(IRQ_MASK_BASE_IDX + 6'h2), 8'h00, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    rd(ba(IRQ_STATUS_BASE_IDX + 6'h2), 8'h08, RESP_OKAY);
    wr(ba(IO_CONFIG_ONE_IDX), 8'h00, RESP_OKAY);
    wr(ba(IRQ_STATUS_BASE_IDX + 6'h2), 8'h08, RESP_OKAY);
    rd(ba(IRQ_STATUS_BASE_IDX + 6'h2), 8'h00, RESP_OKAY);
    end_of_test();
  end
endmodule
